// >>> rtl/usb_ep_host_consts.vh
// Register offsets, field positions, reset values and timing counts for the endpoint host controller.
`ifndef USB_EP_HOST_CONSTS_VH
`define USB_EP_HOST_CONSTS_VH

// Own register map (byte offsets on the command APB).
`define REG_CTRL      8'h00
`define REG_CMD       8'h04
`define REG_TXBYTE    8'h08
`define REG_SETUP_LO  8'h0c
`define REG_SETUP_HI  8'h10
`define REG_STATUS    8'h14

// Device register map (byte offsets on the device APB), one word per endpoint.
`define DEV_CSR_BASE  8'h30
`define DEV_FIFO_BASE 8'h50

// Flag positions in the device endpoint_ctrl_status register.
`define CSR_TX_COMPLETE    0
`define CSR_SETUP     2
`define CSR_TXRDY     4

// Control register fields.
`define CTRL_CONN     0
`define CTRL_EP_LSB   4
`define CTRL_RESET    32'h0000_0000

// Command register fields and codes.
`define CMD_SETUP     2'h1
`define CMD_SEND      2'h2
`define CMD_LAST      2

// Status register fields.
`define ST_BUSY       0
`define ST_VBUS       1
`define ST_PULLUP     2
`define ST_RSTDUE     3
`define ST_SETUPV     4
`define ST_ERROR      5
`define ST_DONE       6
`define ST_PHASE_LSB  8

// Control transfer phases.
`define PH_IDLE       2'h0
`define PH_SETUP      2'h1
`define PH_DATA_IN    2'h2
`define PH_STATUS_OUT 2'h3

// Sizes and the dual-bank endpoint map.
`define SETUP_BYTES   8
`define MAX_PKT       64
`define DUAL_BANK_MAP 8'h36

// Timing.
`define CLK_HZ        50000000
`define T_CONNECT_MS  100
`define T_BUSRST_MS   100
`define CONNECT_CYC   (`T_CONNECT_MS * (`CLK_HZ / 1000))
`define BUSRST_CYC    (`T_BUSRST_MS * (`CLK_HZ / 1000))

`endif

// >>> rtl/apb_master_port.v
// APB master that carries one single-word transfer per start pulse.
`timescale 1ns/1ps
module apb_master_port
(
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // Request side
  input  wire        start,
  input  wire        reqWrite,
  input  wire [7:0]  reqAddr,
  input  wire [31:0] reqWdata,
  output reg         done,
  output reg         doneErr,
  output reg  [31:0] rdata,
  // APB master side
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [7:0]  paddr,
  output reg  [31:0] pwdata,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= 8'h00;
      pwdata  <= 32'h0000_0000;
      rdata   <= 32'h0000_0000;
      done    <= 1'b0;
      doneErr <= 1'b0;
    end
    else
    begin
      done    <= 1'b0;
      doneErr <= 1'b0;
      if (!psel && start)
      begin
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= reqWrite;
        paddr   <= reqAddr;
        pwdata  <= reqWdata;
      end
      else if (psel && !penable)
        penable <= 1'b1;
      else if (psel && penable && pready)
      begin
        // The request is held unchanged until this edge; only here is read data taken.
        psel    <= 1'b0;
        penable <= 1'b0;
        rdata   <= prdata;
        done    <= 1'b1;
        doneErr <= pslverr;
      end
    end
  end

endmodule

// >>> rtl/usb_ep_host.v
// Host-side controller that connects the pull-up, watches bus power and services device endpoints.
`timescale 1ns/1ps
`include "usb_ep_host_consts.vh"
module usb_ep_host
#(
  parameter CONNECT_CYCLES = `CONNECT_CYC,
  parameter BUSRST_CYCLES  = `BUSRST_CYC,
  parameter MAX_PKT        = `MAX_PKT,
  parameter DUAL_BANK      = `DUAL_BANK_MAP
)
(
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // Command APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  // Device APB master
  output wire        devPsel,
  output wire        devPenable,
  output wire        devPwrite,
  output wire [7:0]  devPaddr,
  output wire [31:0] devPwdata,
  input  wire [31:0] devPrdata,
  input  wire        devPready,
  input  wire        devPslverr,
  // Board lines
  input  wire        vbusSense,
  output wire        pullupCtrlN
);

  localparam S_IDLE     = 4'd0;
  localparam S_SU_POLL  = 4'd1;
  localparam S_SU_READ  = 4'd2;
  localparam S_SU_CLR   = 4'd3;
  localparam S_TX_POLL  = 4'd4;
  localparam S_TX_WRITE = 4'd5;
  localparam S_TX_SET   = 4'd6;
  localparam S_TX_CLRP  = 4'd7;
  localparam S_TX_WAITC = 4'd8;
  localparam S_TX_CLRC  = 4'd9;

  reg [3:0]  stateReg;
  reg        reqPendReg;
  reg        connEnableReg;
  reg [2:0]  epSelReg;
  reg [6:0]  byteIdxReg;
  reg [6:0]  txFillReg;
  reg        lastReg;
  reg        prevPendReg;
  reg [7:0]  csrLastReg;
  reg [63:0] setupBufReg;
  reg        setupValidReg;
  reg        errorReg;
  reg        doneReg;
  reg [1:0]  phaseReg;
  reg        pullupOnReg;
  reg        resetDueReg;
  reg [22:0] timerReg;
  reg [7:0]  txMem [0:MAX_PKT-1];

  reg        busWrite;
  reg [7:0]  busAddr;
  reg [31:0] busWdata;
  wire       busDone;
  wire       busErr;
  wire [31:0] busRdata;
  wire       busStart;
  wire [7:0] csrAddr;
  wire [7:0] fifoAddr;
  wire       wrAccess;
  wire       setupAccess;
  wire       mapped;
  wire       cmdSetup;
  wire       cmdSend;
  wire       epDual;
  wire       cmdOk;
  wire       finishTx;
  wire [7:0] rdByte;

  assign pullupCtrlN = ~pullupOnReg;
  assign pready      = penable;
  assign wrAccess    = psel && penable && pwrite;
  assign setupAccess = psel && !penable;
  assign mapped      = (paddr == `REG_CTRL) || (paddr == `REG_CMD) || (paddr == `REG_TXBYTE) ||
                       (paddr == `REG_SETUP_LO) || (paddr == `REG_SETUP_HI) || (paddr == `REG_STATUS);
  assign csrAddr     = `DEV_CSR_BASE + {3'b000, epSelReg, 2'b00};
  assign fifoAddr    = `DEV_FIFO_BASE + {3'b000, epSelReg, 2'b00};
  assign epDual      = DUAL_BANK[epSelReg];
  assign cmdSetup    = wrAccess && (paddr == `REG_CMD) && (pwdata[1:0] == `CMD_SETUP);
  assign cmdSend     = wrAccess && (paddr == `REG_CMD) && (pwdata[1:0] == `CMD_SEND);
  // A setup command on a dual-bank endpoint is refused (a send is not), as is either command while busy or unplugged.
  assign cmdOk       = (stateReg == S_IDLE) && pullupOnReg && !epDual;
  assign busStart    = (stateReg != S_IDLE) && !reqPendReg;
  assign rdByte      = busRdata[7:0];
  assign finishTx    = busDone && !lastReg &&
                       (((stateReg == S_TX_SET) && !prevPendReg) || (stateReg == S_TX_CLRP));

  // Device access chosen by the sequencer state.
  always @*
  begin
    busWrite = 1'b0;
    busAddr  = csrAddr;
    busWdata = 32'h0000_0000;
    case (stateReg)
      S_SU_READ:
        busAddr = fifoAddr;
      S_SU_CLR:
      begin
        busWrite = 1'b1;
        busWdata = {24'h000000, csrLastReg & ~(8'h01 << `CSR_SETUP)};
      end
      S_TX_WRITE:
      begin
        busWrite = 1'b1;
        busAddr  = fifoAddr;
        busWdata = {24'h000000, txMem[byteIdxReg[5:0]]};
      end
      S_TX_SET:
      begin
        busWrite = 1'b1;
        busWdata = {24'h000000, csrLastReg | (8'h01 << `CSR_TXRDY)};
      end
      S_TX_CLRP:
      begin
        busWrite = 1'b1;
        busWdata = {24'h000000, (csrLastReg | (8'h01 << `CSR_TXRDY)) & ~(8'h01 << `CSR_TX_COMPLETE)};
      end
      S_TX_CLRC:
      begin
        busWrite = 1'b1;
        busWdata = {24'h000000, csrLastReg & ~(8'h01 << `CSR_TX_COMPLETE)};
      end
      default:
        busWrite = 1'b0;
    endcase
  end

  apb_master_port u_master
  (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .start    (busStart),
    .reqWrite (busWrite),
    .reqAddr  (busAddr),
    .reqWdata (busWdata),
    .done     (busDone),
    .doneErr  (busErr),
    .rdata    (busRdata),
    .psel     (devPsel),
    .penable  (devPenable),
    .pwrite   (devPwrite),
    .paddr    (devPaddr),
    .pwdata   (devPwdata),
    .prdata   (devPrdata),
    .pready   (devPready),
    .pslverr  (devPslverr)
  );

  // Transmit staging buffer, filled one byte per write.
  always @(posedge clk_sys)
  begin
    if (wrAccess && (paddr == `REG_TXBYTE) && (txFillReg < MAX_PKT))
      txMem[txFillReg[5:0]] <= pwdata[7:0];
  end

  // Pull-up connect timing and bus power watch.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pullupOnReg <= 1'b0;
      resetDueReg <= 1'b0;
      timerReg    <= 23'd0;
    end
    else if (!vbusSense)
    begin
      // Loss of bus power is a disconnect; the pull-up must not feed the host.
      pullupOnReg <= 1'b0;
      resetDueReg <= 1'b0;
      timerReg    <= 23'd0;
    end
    else if (!pullupOnReg)
    begin
      timerReg <= timerReg + 23'd1;
      if (connEnableReg || (timerReg == CONNECT_CYCLES - 1))
      begin
        pullupOnReg <= 1'b1;
        timerReg    <= 23'd0;
      end
    end
    else if (!resetDueReg)
    begin
      timerReg <= timerReg + 23'd1;
      if (timerReg == BUSRST_CYCLES - 1)
        resetDueReg <= 1'b1;
    end
  end

  // Registers, sequencer and flags.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateReg      <= S_IDLE;
      reqPendReg    <= 1'b0;
      connEnableReg <= 1'b0;
      epSelReg      <= 3'd0;
      byteIdxReg    <= 7'd0;
      txFillReg     <= 7'd0;
      lastReg       <= 1'b0;
      prevPendReg   <= 1'b0;
      csrLastReg    <= 8'h00;
      setupBufReg   <= 64'h0;
      setupValidReg <= 1'b0;
      errorReg      <= 1'b0;
      doneReg       <= 1'b0;
      phaseReg      <= `PH_IDLE;
    end
    else
    begin
      if (busStart)
        reqPendReg <= 1'b1;
      else if (busDone)
        reqPendReg <= 1'b0;
      if (wrAccess && (paddr == `REG_CTRL) && (stateReg == S_IDLE))
      begin
        connEnableReg <= pwdata[`CTRL_CONN];
        epSelReg      <= pwdata[`CTRL_EP_LSB+2:`CTRL_EP_LSB];
      end
      if (wrAccess && (paddr == `REG_TXBYTE) && (txFillReg < MAX_PKT))
        txFillReg <= txFillReg + 7'd1;
      // Software clears by writing one; a hardware set in the same cycle wins below.
      if (wrAccess && (paddr == `REG_STATUS))
      begin
        if (pwdata[`ST_SETUPV])
          setupValidReg <= 1'b0;
        if (pwdata[`ST_ERROR])
          errorReg <= 1'b0;
        if (pwdata[`ST_DONE])
          doneReg <= 1'b0;
      end
      if ((cmdSetup && !cmdOk) || (cmdSend && !((stateReg == S_IDLE) && pullupOnReg)))
        errorReg <= 1'b1;
      if ((busDone && busErr) || (wrAccess && (paddr == `REG_TXBYTE) && (txFillReg >= MAX_PKT)))
        errorReg <= 1'b1;
      // Only status reads are kept, so FIFO bytes are never written back as flags.
      if (busDone && !busWrite && (busAddr == csrAddr))
        csrLastReg <= rdByte;
      if (!vbusSense)
        phaseReg <= `PH_IDLE;
      case (stateReg)
        S_IDLE:
        begin
          if (cmdSetup && cmdOk)
            stateReg <= S_SU_POLL;
          else if (cmdSend && (stateReg == S_IDLE) && pullupOnReg)
          begin
            lastReg    <= pwdata[`CMD_LAST];
            byteIdxReg <= 7'd0;
            stateReg   <= S_TX_POLL;
          end
        end
        S_SU_POLL:
          if (busDone && rdByte[`CSR_SETUP])
          begin
            byteIdxReg <= 7'd0;
            stateReg   <= S_SU_READ;
          end
        S_SU_READ:
          if (busDone)
          begin
            setupBufReg <= {rdByte, setupBufReg[63:8]};
            byteIdxReg  <= byteIdxReg + 7'd1;
            if (byteIdxReg == `SETUP_BYTES - 1)
              stateReg <= S_SU_CLR;
          end
        S_SU_CLR:
          if (busDone)
          begin
            setupValidReg <= 1'b1;
            doneReg       <= 1'b1;
            prevPendReg   <= 1'b0;
            phaseReg      <= `PH_SETUP;
            stateReg      <= S_IDLE;
          end
        S_TX_POLL:
          // A packet is loaded only once the previous one has left the FIFO.
          if (busDone && !rdByte[`CSR_TXRDY])
            stateReg <= (txFillReg == 7'd0) ? S_TX_SET : S_TX_WRITE;
        S_TX_WRITE:
          if (busDone)
          begin
            byteIdxReg <= byteIdxReg + 7'd1;
            if (byteIdxReg + 7'd1 == txFillReg)
              stateReg <= S_TX_SET;
          end
        S_TX_SET:
          if (busDone)
          begin
            csrLastReg <= csrLastReg | (8'h01 << `CSR_TXRDY);
            stateReg   <= prevPendReg ? S_TX_CLRP : (lastReg ? S_TX_WAITC : S_IDLE);
          end
        S_TX_CLRP:
          if (busDone)
          begin
            prevPendReg <= 1'b0;
            stateReg    <= lastReg ? S_TX_WAITC : S_IDLE;
          end
        S_TX_WAITC:
          if (busDone && rdByte[`CSR_TX_COMPLETE])
            stateReg <= S_TX_CLRC;
        S_TX_CLRC:
          if (busDone)
          begin
            prevPendReg <= 1'b0;
            txFillReg   <= 7'd0;
            doneReg     <= 1'b1;
            // A zero-length last packet closes the transfer as its status IN stage.
            phaseReg    <= (txFillReg == 7'd0) ? `PH_IDLE : `PH_STATUS_OUT;
            stateReg    <= S_IDLE;
          end
        default:
          stateReg <= S_IDLE;
      endcase
      if (finishTx)
      begin
        prevPendReg <= 1'b1;
        txFillReg   <= 7'd0;
        doneReg     <= 1'b1;
        phaseReg    <= (phaseReg == `PH_STATUS_OUT) ? `PH_STATUS_OUT : `PH_DATA_IN;
      end
    end
  end

  // Read data is registered in the setup cycle, so every access has one wait-free access phase.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setupAccess)
    begin
      pslverr <= !mapped;
      case (paddr)
        `REG_CTRL:     prdata <= {25'h0, epSelReg, 3'b000, connEnableReg};
        `REG_TXBYTE:   prdata <= {25'h0, txFillReg};
        `REG_SETUP_LO: prdata <= setupBufReg[31:0];
        `REG_SETUP_HI: prdata <= setupBufReg[63:32];
        `REG_STATUS:   prdata <= {22'h0, phaseReg, 1'b0, doneReg, errorReg, setupValidReg,
                                  resetDueReg, pullupOnReg, vbusSense, stateReg != S_IDLE};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// >>> tb/usb_ep_host_props.sv
// Port checks for the endpoint host controller.
`timescale 1ns/1ps
module usb_ep_host_props
#(
  parameter       CONNECT_CYCLES = 50,
  parameter [7:0] DUAL_BANK      = 8'h36
)
(
  // Clock and reset
  input wire        clk_sys,
  input wire        rst_n,
  // Device bus
  input wire        devPsel,
  input wire        devPenable,
  input wire        devPwrite,
  input wire [7:0]  devPaddr,
  input wire [31:0] devPwdata,
  input wire [31:0] devPrdata,
  input wire        devPready,
  // Board lines
  input wire        vbusSense,
  input wire        pullupCtrlN
);
  reg  [31:0] vbusCnt;
  reg  [3:0]  fifoRd;
  reg         setupSeen;
  reg         txBusy;
  wire        xfer  = devPsel && devPenable && devPready;
  wire        csrA  = devPaddr >= 8'h30 && devPaddr < 8'h50;
  wire        fifoA = devPaddr >= 8'h50 && devPaddr < 8'h70;
  wire [7:0]  fifoOff = devPaddr - 8'h50;
  wire        csrWr = xfer && csrA && devPwrite;
  wire        csrRd = xfer && csrA && !devPwrite;
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      vbusCnt   <= 32'h0;
      fifoRd    <= 4'h0;
      setupSeen <= 1'b0;
      txBusy    <= 1'b0;
    end
    else
    begin
      vbusCnt <= vbusSense ? vbusCnt + 32'h1 : 32'h0;
      if (xfer && fifoA && !devPwrite && fifoRd != 4'hf)
        fifoRd <= fifoRd + 4'h1;
      if (csrRd && devPrdata[2])
        setupSeen <= 1'b1;
      // A write that leaves the setup flag clear closes the setup read window.
      if (csrWr && !devPwdata[2])
      begin
        setupSeen <= 1'b0;
        fifoRd    <= 4'h0;
      end
      if (csrWr && devPwdata[4])
        txBusy <= 1'b1;
      if (csrRd && !devPrdata[4])
        txBusy <= 1'b0;
    end
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  pullup_drop_a: assert property (!vbusSense [*4] |-> pullupCtrlN)
    else $error("pull-up on without bus power");
  connect_bound_a: assert property (vbusCnt > CONNECT_CYCLES + 4 |-> !pullupCtrlN)
    else $error("pull-up late after bus power");
  request_hold_a: assert property (devPsel && !devPready |=> devPsel && $stable(devPaddr)
    && $stable(devPwrite) && $stable(devPwdata)) else $error("device request changed early");
  setup_phase_a: assert property ($rose(devPsel) |-> !devPenable ##1 devPenable)
    else $error("device access without setup cycle");
  idle_gap_a: assert property (xfer |=> !devPsel && !devPenable)
    else $error("device transfers without idle cycle");
  setup_read_a: assert property (csrWr && !devPwdata[2] && setupSeen |-> fifoRd >= 4'h8)
    else $error("setup flag cleared before eight reads");
  idle_load_a: assert property (xfer && fifoA && devPwrite |-> !txBusy)
    else $error("fifo loaded while packet pending");
  single_bank_a: assert property (devPsel && fifoA && !devPwrite |-> !DUAL_BANK[fifoOff[4:2]])
    else $error("setup read on dual-bank endpoint");
endmodule
bind usb_ep_host usb_ep_host_props #(.CONNECT_CYCLES(CONNECT_CYCLES), .DUAL_BANK(DUAL_BANK)) props
(
  .clk_sys    (clk_sys),
  .rst_n      (rst_n),
  .devPsel    (devPsel),
  .devPenable (devPenable),
  .devPwrite  (devPwrite),
  .devPaddr   (devPaddr),
  .devPwdata  (devPwdata),
  .devPrdata  (devPrdata),
  .devPready  (devPready),
  .vbusSense  (vbusSense),
  .pullupCtrlN(pullupCtrlN)
);

// >>> tb/usb_ep_dev_model.sv
// Behavioural endpoint device behind the controller's device bus.
`timescale 1ns/1ps
module usb_ep_dev_model
(
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // Device bus slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Scenario control and observation
  input  wire        slow,
  input  wire        setupGo,
  output reg  [7:0]  setupFlag,
  output reg  [7:0]  tx_complete,
  output reg  [7:0]  pktLen,
  output reg  [7:0]  pktCount
);
  reg  [7:0]  txRdy;
  reg  [3:0]  waitCnt;
  reg  [3:0]  rdPtr;
  reg  [7:0]  fill;
  reg  [4:0]  ackCnt;
  reg  [31:0] junk;
  wire        csrA  = paddr >= 8'h30 && paddr < 8'h50;
  wire        fifoA = paddr >= 8'h50 && paddr < 8'h70;
  wire [7:0]  epOff = paddr - (csrA ? 8'h30 : 8'h50);
  wire [2:0]  ep    = epOff[4:2];
  wire        xfer  = psel && penable && pready;
  wire [31:0] rd    = csrA ? {27'h0, txRdy[ep], 1'b0, setupFlag[ep], 1'b0, tx_complete[ep]}
                           : {24'h0, 8'h80 | {4'h0, rdPtr}};
  wire        intrPending = |(setupFlag | tx_complete);
  // Slow mode stretches the access so the controller must hold its request.
  assign pready  = penable && (!slow || waitCnt == 4'h3);
  assign pslverr = penable && !csrA && !fifoA;
  // Outside a completing access the data lines churn rather than hold.
  assign prdata  = xfer ? rd : junk;
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      setupFlag <= 8'h00;
      tx_complete    <= 8'h00;
      txRdy     <= 8'h00;
      pktLen    <= 8'h00;
      pktCount  <= 8'h00;
      waitCnt   <= 4'h0;
      rdPtr     <= 4'h0;
      fill      <= 8'h00;
      ackCnt    <= 5'h00;
      junk      <= 32'h0;
    end
    else
    begin
      junk    <= ~junk + 32'h0001_0001;
      waitCnt <= (psel && penable && !pready) ? waitCnt + 4'h1 : 4'h0;
      if (setupGo)
      begin
        setupFlag[0] <= 1'b1;
        rdPtr        <= 4'h0;
      end
      if (xfer && fifoA && !pwrite)
        rdPtr <= rdPtr + 4'h1;
      if (xfer && fifoA && pwrite)
        fill <= fill + 8'h01;
      if (xfer && csrA && pwrite)
      begin
        setupFlag[ep] <= setupFlag[ep] & pwdata[2];
        tx_complete[ep]    <= tx_complete[ep] & pwdata[0];
        txRdy[ep]     <= txRdy[ep] | pwdata[4];
      end
      // IN tokens are refused until a packet is marked ready.
      ackCnt <= (|txRdy) ? ackCnt + 5'h01 : 5'h00;
      if (ackCnt == 5'h10)
      begin
        tx_complete   <= tx_complete | txRdy;
        txRdy    <= 8'h00;
        pktLen   <= fill;
        pktCount <= pktCount + 8'h01;
        fill     <= 8'h00;
        ackCnt   <= 5'h00;
      end
    end
endmodule

// >>> tb/usb_ep_host_test.sv
// Self-checking bench for the endpoint host controller.
`timescale 1ns/1ps
module usb_ep_host_test;
  reg         clk_sys;
  reg         rst_n;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        devPsel;
  wire        devPenable;
  wire        devPwrite;
  wire [7:0]  devPaddr;
  wire [31:0] devPwdata;
  wire [31:0] devPrdata;
  wire        devPready;
  wire        devPslverr;
  reg         vbusSense;
  wire        pullupCtrlN;
  reg         slow;
  reg         setupGo;
  wire [7:0]  setupFlag;
  wire [7:0]  tx_complete;
  wire [7:0]  pktLen;
  wire [7:0]  pktCount;
  reg  [31:0] rv;
  reg         rerr;
  integer     bad_count;
  integer     n_checks;
  integer     i;
  usb_ep_host #(.CONNECT_CYCLES(50), .BUSRST_CYCLES(50)) DUT
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .devPsel(devPsel), .devPenable(devPenable), .devPwrite(devPwrite), .devPaddr(devPaddr),
    .devPwdata(devPwdata), .devPrdata(devPrdata), .devPready(devPready),
    .devPslverr(devPslverr), .vbusSense(vbusSense), .pullupCtrlN(pullupCtrlN)
  );
  usb_ep_dev_model dev
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(devPsel), .penable(devPenable), .pwrite(devPwrite),
    .paddr(devPaddr), .pwdata(devPwdata), .prdata(devPrdata), .pready(devPready),
    .pslverr(devPslverr), .slow(slow), .setupGo(setupGo), .setupFlag(setupFlag),
    .tx_complete(tx_complete), .pktLen(pktLen), .pktCount(pktCount)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task summarize;
  begin
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // One APB transfer; the request is held until pready is seen high at an edge.
  task apb(input wr, input [7:0] a, input [31:0] d);
    integer k;
  begin
    k = 0;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      k = k + 1;
    end
    while (pready !== 1'b1 && k < 100);
    rv   = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 100)
    begin
      bad_count = bad_count + 1;
      summarize;
    end
  end
  endtask
  task waitDone;
    integer k;
  begin
    k  = 0;
    rv = 32'h0;
    while (rv[6] !== 1'b1 && k < 400)
    begin
      apb(1'b0, 8'h14, 32'h0);
      k = k + 1;
    end
    if (k >= 400)
    begin
      bad_count = bad_count + 1;
      summarize;
    end
    apb(1'b1, 8'h14, 32'h40);
  end
  endtask
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    bad_count = bad_count + 1;
    summarize;
  end
  initial
  begin
    bad_count = 0;
    n_checks  = 0;
    rst_n     = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    vbusSense = 1'b0;
    slow      = 1'b0;
    setupGo   = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check(rv, 32'h0);
    check({31'h0, pullupCtrlN}, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, rerr}, 32'h1);
    $display("test reset done");
    vbusSense <= 1'b1;
    repeat (58) @(posedge clk_sys);
    check({31'h0, pullupCtrlN}, 32'h0);
    repeat (58) @(posedge clk_sys);
    apb(1'b0, 8'h14, 32'h0);
    check(rv & 32'h0e, 32'h0e);
    vbusSense <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check({31'h0, pullupCtrlN}, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    check(rv & 32'h0e, 32'h0);
    vbusSense <= 1'b1;
    apb(1'b1, 8'h00, 32'h1);
    repeat (6) @(posedge clk_sys);
    check({31'h0, pullupCtrlN}, 32'h0);
    $display("test connect done");
    slow <= 1'b1;
    apb(1'b1, 8'h04, 32'h1);
    repeat (20) @(posedge clk_sys);
    setupGo <= 1'b1;
    @(posedge clk_sys);
    setupGo <= 1'b0;
    waitDone;
    apb(1'b0, 8'h0c, 32'h0);
    check(rv, 32'h8382_8180);
    apb(1'b0, 8'h10, 32'h0);
    check(rv, 32'h8786_8584);
    check({24'h0, setupFlag}, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check(rv & 32'h30, 32'h10);
    check(rv & 32'h300, 32'h100);
    $display("test setup done");
    slow <= 1'b0;
    for (i = 0; i < 3; i = i + 1)
      apb(1'b1, 8'h08, i);
    apb(1'b0, 8'h08, 32'h0);
    check(rv, 32'h3);
    apb(1'b1, 8'h04, 32'h2);
    waitDone;
    apb(1'b1, 8'h04, 32'h6);
    waitDone;
    check({24'h0, pktLen}, 32'h0);
    check({24'h0, pktCount}, 32'h2);
    check({24'h0, tx_complete}, 32'h0);
    $display("test send done");
    for (i = 0; i < 65; i = i + 1)
      apb(1'b1, 8'h08, i);
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, rv[5]}, 32'h1);
    apb(1'b1, 8'h14, 32'h20);
    apb(1'b1, 8'h04, 32'h6);
    waitDone;
    check({24'h0, pktLen}, 32'h40);
    check({24'h0, pktCount}, 32'h3);
    apb(1'b0, 8'h14, 32'h0);
    check(rv & 32'h300, 32'h300);
    $display("test overfill done");
    apb(1'b1, 8'h00, 32'h11);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, rv[5]}, 32'h1);
    $display("test dual bank done");
    summarize;
  end
endmodule
